// ==== pkg/wdt_pkg.sv ====
// watchdog and reset-cause package: offsets, fields, reset values, counts
package wdt_pkg;
  // ----------------------------------------------------------------------
  // register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;

  // ----------------------------------------------------------------------
  // reset_cause_status fields
  // ----------------------------------------------------------------------
  localparam int unsigned STS_POR = 0;
  localparam int unsigned STS_PIN = 1;
  localparam int unsigned STS_BOD = 2;
  localparam int unsigned STS_WDR = 3;
  localparam logic [3:0]  STS_RESET = 4'h1;

  // ----------------------------------------------------------------------
  // watchdog_control fields
  // ----------------------------------------------------------------------
  localparam int unsigned CTL_PRE_LO = 0;
  localparam int unsigned CTL_WDE    = 3;
  localparam int unsigned CTL_CE     = 4;
  localparam int unsigned CTL_PRE_HI = 5;
  localparam int unsigned CTL_IE     = 6;
  localparam int unsigned CTL_IF     = 7;
  localparam logic [3:0]  PRESC_RESET = 4'h0;
  localparam logic [3:0]  PRESC_MAX   = 4'h9;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam logic [2:0]  CE_HOLD_CYCLES = 3'h4;
  localparam int unsigned BASE_TIMEOUT   = 2048;
  localparam int unsigned WDT_OSC_HZ     = 128000;
  localparam int unsigned CLK_HZ         = 25000000;
  // osc ticks must be far apart for the edge detector to see each one
  localparam int unsigned CLKS_PER_TICK  = CLK_HZ / WDT_OSC_HZ;

  // ----------------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_STOP = 4'b0001,
    MODE_IRQ  = 4'b0010,
    MODE_RST  = 4'b0100,
    MODE_BOTH = 4'b1000
  } mode_t;
endpackage

// ==== rtl/wdt_counter.sv ====
// watchdog time-out counter clocked by oscillator tick enables
`timescale 1ns/10ps
module wdt_counter #(
  parameter int unsigned CNT_W = 20
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // control
  input  wire logic       tick,
  input  wire logic       clr,
  input  wire logic [3:0] sel,
  // event
  output logic            timeout
);
  // ----------------------------------------------------------------------
  // period decode
  // ----------------------------------------------------------------------
  // reserved codes run at the longest period rather than something odd
  function automatic logic [CNT_W:0] limit_of(input logic [3:0] s);
    logic [3:0] c;
    c = (s > wdt_pkg::PRESC_MAX) ? wdt_pkg::PRESC_MAX : s;
    limit_of = (CNT_W+1)'(wdt_pkg::BASE_TIMEOUT) << c;
  endfunction

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             hit;

  assign hit     = tick && ({1'b0, cnt_q} == limit_of(sel) - 1'b1);
  assign timeout = hit && !clr;

  // next count: restart clears, time-out wraps back to zero
  always_comb begin
    cnt_d = cnt_q;
    if (clr || hit) begin
      cnt_d = '0; // see R25
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1; // see R15
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_restart;
    @(posedge clk) disable iff (!arst_n) clr |=> (cnt_q == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear"); // see R25
endmodule // wdt_counter

// ==== rtl/wdt_top.sv ====
// watchdog timer with change protection and reset-cause flags
// What the document requires
// R1: change-enable self-clears four system clocks after being set.
// R2: clearing reset-enable or changing prescaler needs change-enable set.
// R3: reset-enable reads one while the watchdog-reset flag is set.
// R4: watchdog-reset flag set by watchdog reset, cleared by power-on or zero write.
// R5: brown-out flag set by brown-out reset, cleared by power-on or zero write.
// R6: pin flag set by pin reset, cleared by power-on or zero write.
// R7: power-on flag set at power-on, cleared only by writing zero.
// R8: status bits 7 to 4 always read zero.
// R9: interrupt flag set on time-out in interrupt modes, cleared by vector or one.
// R10: interrupt request needs flag, interrupt enable and global enable.
// R11: reset and interrupt enables pick mode; fuse forces reset mode.
// R12: combined mode: first time-out flags; vector clears enable and flag.
// R13: combined mode: time-out with flag still pending issues system reset.
// R14: software re-arms interrupt enable after each interrupt, not in handler.
// R15: prescaler code picks 2048 doubling to 1048576 oscillator cycles.
// R16: control layout: flag, enable, pre3, change, reset, pre2..0; zero reset.
// R17: software restarts the counter before changing the prescaler.
// R18: watchdog stays enabled across its own reset.
// R19: init software clears watchdog-reset flag then reset-enable.
// R20: software reads reset causes then clears them early.
// R21: timed sequence: set change and reset enable, then one write within four.
// R22: counter counts cycles of the separate watchdog oscillator.
// R23: fuse locks reset-enable at one and interrupt enable at zero.
// R24: reset-mode time-out gives one system clock reset pulse.
// R25: restart instruction clears the counter to zero.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
module wdt_top #(
  parameter int unsigned CNT_W = 20
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu side
  input  wire logic        restart,
  input  wire logic        cpu_status_global_irq,
  input  wire logic        irq_vector_ack,
  output logic             irq_req,
  // asynchronous inputs: oscillator, detectors, fuse
  input  wire logic        wdt_osc,
  input  wire logic        brownout_event,
  input  wire logic        pin_event,
  input  wire logic        always_on_fuse,
  // reset request to the system
  output logic             wdt_sys_reset
);
  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       osc_old_q;
  logic       osc_rise;
  logic       bod_s;
  logic       pin_s;
  logic       fuse_s;

  // two flops per pin; the edge detector looks only at the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q   <= 4'h0;
      sync2_q   <= 4'h0;
      osc_old_q <= 1'b0;
    end else begin
      sync1_q   <= {always_on_fuse, pin_event, brownout_event, wdt_osc};
      sync2_q   <= sync1_q;
      osc_old_q <= sync2_q[0];
    end
  end

  assign osc_rise = sync2_q[0] && !osc_old_q; // see R22
  assign bod_s    = sync2_q[1];
  assign pin_s    = sync2_q[2];
  assign fuse_s   = sync2_q[3];

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [3:0]  sts_q;
  logic [3:0]  sts_d;
  logic        irqf_q;
  logic        irqf_d;
  logic        ie_q;
  logic        ie_d;
  logic        ce_q;
  logic        ce_d;
  logic [2:0]  ce_cnt_q;
  logic [2:0]  ce_cnt_d;
  logic        wde_q;
  logic        wde_d;
  logic [3:0]  presc_q;
  logic [3:0]  presc_d;
  logic        rst_q;
  logic        rst_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  logic        wr_en;
  logic        wr_ctl;
  logic        wr_sts;
  logic        mapped;
  logic [7:0]  w;
  logic        sys_any;
  logic        timeout;
  logic        cnt_clr;
  logic [7:0]  ctl_view;
  wdt_pkg::mode_t mode;

  // bus decode
  assign mapped  = (paddr == wdt_pkg::ADDR_STATUS) || (paddr == wdt_pkg::ADDR_CONTROL);
  assign wr_en   = psel && penable && pwrite;
  assign wr_ctl  = wr_en && (paddr == wdt_pkg::ADDR_CONTROL);
  assign wr_sts  = wr_en && (paddr == wdt_pkg::ADDR_STATUS);
  assign w       = pwdata[7:0];
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rd_q;

  // any system reset source puts the control register back to defaults, except reset-enable while the watchdog-reset flag or fuse is set
  assign sys_any = rst_q || bod_s || pin_s;

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  always_comb begin
    if (fuse_s) begin
      mode = wdt_pkg::MODE_RST; // see R11
    end else begin
      case ({wde_q, ie_q})
        2'b00:   mode = wdt_pkg::MODE_STOP; // see R11
        2'b01:   mode = wdt_pkg::MODE_IRQ;
        2'b10:   mode = wdt_pkg::MODE_RST;
        default: mode = wdt_pkg::MODE_BOTH;
      endcase
    end
  end

  assign cnt_clr = restart || sys_any || (mode == wdt_pkg::MODE_STOP); // see R25

  wdt_counter #(
    .CNT_W (CNT_W)
  ) u_counter (
    .clk     (clk),
    .arst_n  (arst_n),
    .tick    (osc_rise),
    .clr     (cnt_clr),
    .sel     (presc_q),
    .timeout (timeout)
  );

  // ----------------------------------------------------------------------
  // reset-cause flags
  // ----------------------------------------------------------------------
  // zero writes clear; a reset event in the same cycle wins
  always_comb begin
    sts_d = sts_q;
    if (wr_sts) begin
      sts_d = sts_q & w[3:0]; // see R7
    end
    if (rst_q) begin
      sts_d[wdt_pkg::STS_WDR] = 1'b1; // see R4
    end
    if (bod_s) begin
      sts_d[wdt_pkg::STS_BOD] = 1'b1; // see R5
    end
    if (pin_s) begin
      sts_d[wdt_pkg::STS_PIN] = 1'b1; // see R6
    end
  end

  // power-on is the block reset: it sets the power-on flag, clears the rest
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sts_q <= wdt_pkg::STS_RESET; // see R4
    end else begin
      sts_q <= sts_d;
    end
  end

  // ----------------------------------------------------------------------
  // control register, timed change window and time-out actions
  // ----------------------------------------------------------------------
  always_comb begin
    irqf_d   = irqf_q;
    ie_d     = ie_q;
    ce_d     = ce_q;
    ce_cnt_d = ce_cnt_q;
    wde_d    = wde_q;
    presc_d  = presc_q;
    rst_d    = 1'b0;
    // window closes by itself; rewrites inside it do not extend it
    if (ce_q) begin
      ce_cnt_d = ce_cnt_q + 3'h1;
      if (ce_cnt_q == wdt_pkg::CE_HOLD_CYCLES - 3'h1) begin
        ce_d = 1'b0; // see R1
      end
    end
    if (wr_ctl) begin
      ie_d = w[wdt_pkg::CTL_IE];
      if (w[wdt_pkg::CTL_IF]) begin
        irqf_d = 1'b0; // see R9
      end
      if (ce_q) begin
        wde_d   = w[wdt_pkg::CTL_WDE]; // see R2
        presc_d = {w[wdt_pkg::CTL_PRE_HI], w[wdt_pkg::CTL_PRE_LO +: 3]};
      end else begin
        // without the window the enable can only be raised
        wde_d = wde_q || w[wdt_pkg::CTL_WDE]; // see R2
        if (w[wdt_pkg::CTL_CE] && w[wdt_pkg::CTL_WDE]) begin
          ce_d     = 1'b1; // see R21
          ce_cnt_d = 3'h0;
        end
      end
    end
    if (irq_vector_ack && irqf_q) begin
      irqf_d = 1'b0; // see R9
      if (mode == wdt_pkg::MODE_BOTH) begin
        ie_d = 1'b0; // see R12
      end
    end
    if (timeout) begin
      case (mode)
        wdt_pkg::MODE_IRQ: irqf_d = 1'b1; // see R9
        wdt_pkg::MODE_RST: rst_d = 1'b1; // see R24
        wdt_pkg::MODE_BOTH: begin
          if (irqf_q) begin
            rst_d = 1'b1; // see R13
          end else begin
            irqf_d = 1'b1; // see R12
          end
        end
        default: rst_d = 1'b0;
      endcase
    end
    if (sys_any) begin
      irqf_d   = 1'b0; // see R16
      ie_d     = 1'b0;
      ce_d     = 1'b0;
      ce_cnt_d = 3'h0;
      wde_d    = 1'b0;
      presc_d  = wdt_pkg::PRESC_RESET;
    end
    // a pending watchdog-reset flag keeps the watchdog armed through reset
    if (sts_d[wdt_pkg::STS_WDR]) begin
      wde_d = 1'b1; // see R3, R18
    end
    if (fuse_s) begin
      wde_d = 1'b1; // see R23
      ie_d  = 1'b0;
    end
  end

  // reset-enable starts at zero; its power-on value is otherwise undefined
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqf_q   <= 1'b0;
      ie_q     <= 1'b0;
      ce_q     <= 1'b0;
      ce_cnt_q <= 3'h0;
      wde_q    <= 1'b0;
      presc_q  <= wdt_pkg::PRESC_RESET;
      rst_q    <= 1'b0;
    end else begin
      irqf_q   <= irqf_d;
      ie_q     <= ie_d;
      ce_q     <= ce_d;
      ce_cnt_q <= ce_cnt_d;
      wde_q    <= wde_d;
      presc_q  <= presc_d;
      rst_q    <= rst_d;
    end
  end

  assign wdt_sys_reset = rst_q; // see R24 (see R18 for its effect on control)
  assign irq_req = irqf_q && ie_q && cpu_status_global_irq; // see R10

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  assign ctl_view = {irqf_q, ie_q, presc_q[3], ce_q, wde_q, presc_q[2:0]}; // see R16

  // data is captured in the setup cycle so it is stable for the access
  always_comb begin
    rd_d = rd_q;
    if (psel && !penable) begin
      case (paddr)
        wdt_pkg::ADDR_STATUS:  rd_d = {28'h0000000, sts_q}; // see R8
        wdt_pkg::ADDR_CONTROL: rd_d = {24'h000000, ctl_view};
        default:               rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 32'h00000000;
    end else begin
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_ce_clear;
    disable iff (!arst_n || sys_any) $rose(ce_q) |-> ce_q [*4] ##1 !ce_q;
  endproperty
  a_ce_clear: assert property (p_ce_clear) else $error("change window not 4"); // see R1

  property p_protect;
    (wr_ctl && !ce_q && !sys_any) |=> $stable(presc_q);
  endproperty
  a_protect: assert property (p_protect) else $error("prescaler unprotected"); // see R2

  property p_force;
    sts_q[wdt_pkg::STS_WDR] |-> wde_q;
  endproperty
  a_force: assert property (p_force) else $error("reset enable not forced"); // see R3

  property p_wdr_flag;
    rst_q |=> sts_q[wdt_pkg::STS_WDR] && !rst_q;
  endproperty
  a_wdr_flag: assert property (p_wdr_flag) else $error("reset flag or pulse bad"); // see R4

  property p_por_hold;
    $fell(sts_q[wdt_pkg::STS_POR]) |-> $past(wr_sts && !w[wdt_pkg::STS_POR]);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on flag lost"); // see R7

  property p_rsvd;
    (psel && !penable && paddr == wdt_pkg::ADDR_STATUS) |=> prdata[31:4] == 28'h0000000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero"); // see R8

  property p_irq_set;
    (timeout && mode == wdt_pkg::MODE_IRQ && !sys_any) |=> irqf_q;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq flag not set"); // see R9

  property p_irq_req;
    irq_req |-> irqf_q && ie_q && cpu_status_global_irq;
  endproperty
  a_irq_req: assert property (p_irq_req) else $error("irq without enables"); // see R10

  property p_both_rst;
    (timeout && mode == wdt_pkg::MODE_BOTH && irqf_q) |=> rst_q ##1 !rst_q;
  endproperty
  a_both_rst: assert property (p_both_rst) else $error("no combined reset"); // see R13

  property p_fuse;
    fuse_s ##1 fuse_s |-> wde_q && !ie_q;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse lock broken"); // see R23

  property p_stop;
    (mode == wdt_pkg::MODE_STOP) |-> !timeout;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped watchdog fired"); // see R11

  c_reset_pulse: cover property (rst_q);
  c_combined:    cover property (timeout && mode == wdt_pkg::MODE_BOTH && !irqf_q);
  c_timed_seq:   cover property ($rose(ce_q) ##[1:3] wr_ctl);
endmodule // wdt_top

// ==== verification/tb.sv ====
// self-checking testbench for the watchdog and reset-cause block
`timescale 1ns/10ps
module tb;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        restart;
  logic        cpu_status_global_irq;
  logic        irq_vector_ack;
  logic        irq_req;
  logic        wdt_osc = 1'b0;
  logic        brownout_event;
  logic        pin_event;
  logic        always_on_fuse;
  logic        wdt_sys_reset;
  logic [1:0]  osc_div_q = 2'h0;
  logic [31:0] rd;
  logic        err;
  int          mismatches;
  int          tests_run;

  wdt_top #(.CNT_W(20)) wdt_top_inst (
    .clk                   (clk),
    .arst_n                (arst_n),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .restart               (restart),
    .cpu_status_global_irq (cpu_status_global_irq),
    .irq_vector_ack        (irq_vector_ack),
    .irq_req               (irq_req),
    .wdt_osc               (wdt_osc),
    .brownout_event        (brownout_event),
    .pin_event             (pin_event),
    .always_on_fuse        (always_on_fuse),
    .wdt_sys_reset         (wdt_sys_reset)
  );

  // ----------------------------------------------------------------------
  // clocks
  // ----------------------------------------------------------------------
  // 25 MHz system clock
  always #20 clk = ~clk;

  // fast stand-in oscillator, period 4 clocks, so one time-out at code 0 is 8192 clocks
  always @(posedge clk) begin
    osc_div_q <= osc_div_q + 2'h1;
    if (osc_div_q[0]) begin
      wdt_osc <= ~wdt_osc;
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  // one apb transfer; hold keeps psel up so a second setup can follow at once
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic hold);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    // without hold an idle edge follows, so psel is never dropped and raised at once
    if (!hold) begin
      psel <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0, 1'b0);
    chk(rd, exp);
  endtask

  // unlock write followed back to back by the real write
  task automatic timed(input logic [31:0] d);
    apb(wdt_pkg::ADDR_CONTROL, 1'b1, 32'h18, 1'b1);
    apb(wdt_pkg::ADDR_CONTROL, 1'b1, d, 1'b0);
    // change-enable still reads one for one more edge; let it close before a read
    repeat (2) @(posedge clk);
  endtask

  // outputs are looked at on the falling edge, where they have settled
  task automatic probe(input logic use_rst, input logic exp);
    @(negedge clk);
    chk({31'h0, use_rst ? wdt_sys_reset : irq_req}, {31'h0, exp});
    @(posedge clk);
  endtask

  task automatic wait_high(input logic use_rst, input int max);
    int n;
    n = 0;
    @(negedge clk);
    while (((use_rst ? wdt_sys_reset : irq_req) !== 1'b1) && (n < max)) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, use_rst ? wdt_sys_reset : irq_req}, 32'h1);
    @(posedge clk);
  endtask

  task automatic pulse_restart();
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("TB counts: tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // watchdog: the whole run needs about 55k clocks
  // ----------------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    restart = 1'b0;
    cpu_status_global_irq = 1'b0;
    irq_vector_ack = 1'b0;
    brownout_event = 1'b0;
    pin_event = 1'b0;
    always_on_fuse = 1'b0;
    mismatches = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // reset values, reserved bits and the unmapped word
    rdchk(wdt_pkg::ADDR_STATUS, 32'h01);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h00);
    rdchk(8'h08, 32'h00);
    chk({31'h0, err}, 32'h1);
    apb(wdt_pkg::ADDR_STATUS, 1'b1, 32'hFF, 1'b0);
    rdchk(wdt_pkg::ADDR_STATUS, 32'h01);
    apb(wdt_pkg::ADDR_STATUS, 1'b1, 32'h00, 1'b0);
    rdchk(wdt_pkg::ADDR_STATUS, 32'h00);
    // detector events land in their own flags
    pin_event <= 1'b1;
    repeat (3) @(posedge clk);
    pin_event <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(wdt_pkg::ADDR_STATUS, 32'h02);
    brownout_event <= 1'b1;
    repeat (3) @(posedge clk);
    brownout_event <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(wdt_pkg::ADDR_STATUS, 32'h06);
    apb(wdt_pkg::ADDR_STATUS, 1'b1, 32'h00, 1'b0);
    // protected fields refuse plain writes; the unlock window closes by itself
    apb(wdt_pkg::ADDR_CONTROL, 1'b1, 32'h08, 1'b0);
    apb(wdt_pkg::ADDR_CONTROL, 1'b1, 32'h00, 1'b0);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h08);
    apb(wdt_pkg::ADDR_CONTROL, 1'b1, 32'h09, 1'b0);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h08);
    apb(wdt_pkg::ADDR_CONTROL, 1'b1, 32'h18, 1'b1);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h18);
    repeat (6) @(posedge clk);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h08);
    // interrupt mode at code 1; a restart pushes the time-out out again
    pulse_restart();
    timed(32'h41);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h41);
    cpu_status_global_irq <= 1'b1;
    repeat (6000) @(posedge clk);
    pulse_restart();
    repeat (14000) @(posedge clk);
    probe(1'b0, 1'b0);
    wait_high(1'b0, 5000);
    cpu_status_global_irq <= 1'b0;
    probe(1'b0, 1'b0);
    cpu_status_global_irq <= 1'b1;
    probe(1'b0, 1'b1);
    apb(wdt_pkg::ADDR_CONTROL, 1'b1, 32'hC1, 1'b0);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h41);
    // combined mode, vector taken: falls back to reset mode, then resets
    pulse_restart();
    timed(32'h48);
    wait_high(1'b0, 10000);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'hC8);
    irq_vector_ack <= 1'b1;
    @(posedge clk);
    irq_vector_ack <= 1'b0;
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h08);
    wait_high(1'b1, 10000);
    probe(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    rdchk(wdt_pkg::ADDR_STATUS, 32'h08);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h08);
    // combined mode, vector never taken: second time-out resets
    // clear the old cause first, so the next status read shows a fresh one
    apb(wdt_pkg::ADDR_STATUS, 1'b1, 32'h00, 1'b0);
    apb(wdt_pkg::ADDR_CONTROL, 1'b1, 32'h48, 1'b0);
    wait_high(1'b0, 10000);
    probe(1'b1, 1'b0);
    wait_high(1'b1, 10000);
    repeat (3) @(posedge clk);
    rdchk(wdt_pkg::ADDR_STATUS, 32'h08);
    // reset enable stays on until the watchdog-reset flag is cleared
    timed(32'h00);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h08);
    apb(wdt_pkg::ADDR_STATUS, 1'b1, 32'h00, 1'b0);
    timed(32'h00);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h00);
    // programmed fuse locks the mode to reset
    always_on_fuse <= 1'b1;
    repeat (4) @(posedge clk);
    apb(wdt_pkg::ADDR_CONTROL, 1'b1, 32'h40, 1'b0);
    rdchk(wdt_pkg::ADDR_CONTROL, 32'h08);
    give_verdict();
  end
endmodule // tb
